// file: bench/vsil_host_model.sv
// host function block model writing mode and block setpoint
`timescale 1ns/1ps
module vsil_host_model
	import vsil_pkg::*;
(
	// clock
	input  wire logic            core_clk,
	// block parameters
	output vsil_pkg::vsil_mode_t block_operating_mode,
	output vsil_pkg::vsil_cmd_t  block_setpoint,
	output logic                 setpoint_wr
);
	initial begin
		block_operating_mode = VSIL_MODE_AUTO;
		block_setpoint = VSIL_CMD_CLOSE;
		setpoint_wr = 1'b0;
	end
	// one-cycle strobe; a write outside manual only when asked for
	task automatic put(input vsil_mode_t m, input vsil_cmd_t v, input logic w);
		@(posedge core_clk);
		block_operating_mode <= m;
		block_setpoint <= v;
		setpoint_wr <= w;
		@(posedge core_clk);
		setpoint_wr <= 1'b0;
	endtask
endmodule

// file: bench/vsil_top_chk.sv
// port checker for the valve status indicator logic
`timescale 1ns/1ps
module vsil_top_chk
	import vsil_pkg::*;
#(
	parameter int unsigned SELFTEST_CYCLES = 8,
	parameter int unsigned BLINK_CYCLES    = 4,
	parameter int unsigned DEBOUNCE_CYCLES = 3
) (
	// clock and reset
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	input wire logic                  clk_en,
	// inputs
	input wire logic                  bus_activity,
	input wire logic                  dev_ready,
	input wire vsil_pkg::vsil_mode_t  block_operating_mode,
	input wire vsil_pkg::vsil_cmd_t   auto_setpoint,
	input wire vsil_pkg::vsil_cmd_t   block_setpoint,
	input wire logic                  setpoint_wr,
	// outputs
	input wire vsil_pkg::vsil_cmd_t   raw_valve_command,
	input wire logic                  solenoid_drive_zero,
	input wire logic                  solenoid_drive_one,
	input wire vsil_pkg::vsil_lamps_t lamps,
	input wire vsil_pkg::vsil_pos_t   position_readback,
	input wire vsil_pkg::vsil_cfg_t   first_valve_transducer,
	input wire vsil_pkg::vsil_snap_t  io_raw_snapshot
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic [31:0] cnt_q;
	logic [31:0] run_q;
	logic [31:0] hold_q;
	logic        norm;
	logic        man_ok;
	vsil_cfg_t   cf;
	vsil_pins_t  pn;

	// margins of two cycles keep the self-test windows clear of their leading edges
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
		end else if (clk_en && cnt_q < 2 * SELFTEST_CYCLES + 8) begin
			cnt_q <= cnt_q + 32'h1;
		end
	end
	always_ff @(posedge core_clk) begin
		run_q  <= lamps.bus_lamp ? run_q + 32'h1 : 32'h0;
		hold_q <= (bus_activity && dev_ready) ? hold_q + 32'h1 : 32'h0;
	end
	assign norm   = cnt_q >= 2 * SELFTEST_CYCLES + 4;
	assign cf     = first_valve_transducer;
	assign pn     = io_raw_snapshot.pins;
	assign man_ok = clk_en && setpoint_wr && block_setpoint != 2'h3 &&
		block_operating_mode == VSIL_MODE_MANUAL && !pn.dip_sw[DIP_WRITE_PROT];

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_selftest_on: assert property (
		cnt_q >= 3 && cnt_q <= SELFTEST_CYCLES |-> lamps == 7'h7F)
		else $error("lamps dark during self-test on phase");
	a_selftest_off: assert property (
		cnt_q >= SELFTEST_CYCLES + 3 && cnt_q <= 2 * SELFTEST_CYCLES
		|-> lamps == 7'h0)
		else $error("lamps lit during self-test off phase");
	a_bus_dark: assert property (
		norm && !bus_activity |=> !lamps.bus_lamp)
		else $error("bus lamp lit without traffic");
	a_blink_half: assert property (
		$fell(lamps.bus_lamp) && norm && hold_q > run_q + 1
		|-> run_q == BLINK_CYCLES)
		else $error("blink half period wrong");
	a_limit_follow: assert property (
		norm && !pn.dip_sw[DIP_FACTORY] |-> lamps.upper_limit_lamp ==
		pn.top_sensor && lamps.lower_limit_lamp == pn.bot_sensor)
		else $error("limit lamp differs from sensor");
	a_cmd_manual: assert property (
		man_ok ##1 (clk_en && !setpoint_wr &&
		block_operating_mode == VSIL_MODE_MANUAL)
		|=> raw_valve_command == $past(block_setpoint, 2))
		else $error("manual write not applied");
	a_cmd_auto: assert property (
		clk_en && block_operating_mode == VSIL_MODE_AUTO &&
		auto_setpoint != 2'h3 |-> ##2 raw_valve_command ==
		$past(auto_setpoint, 2))
		else $error("automatic command not applied");
	a_drive_single: assert property (
		(cf.actuation_style == VSIL_STYLE_SINGLE && !cf.out_sel &&
		raw_valve_command != VSIL_CMD_STOP) ##1 ($stable(cf) &&
		$stable(raw_valve_command)) |-> !solenoid_drive_one &&
		solenoid_drive_zero == ((raw_valve_command == VSIL_CMD_OPEN) ^
		cf.reverse))
		else $error("single coil level wrong");
	a_pos_opened: assert property (
		pn.top_sensor && cf.open_sel == VSIL_SEL_TOP && $stable(cf)
		|=> position_readback == VSIL_POS_OPENED)
		else $error("opened switch not reported");
endmodule

bind vsil_top vsil_top_chk #(
	.SELFTEST_CYCLES(SELFTEST_CYCLES),
	.BLINK_CYCLES(BLINK_CYCLES),
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
	.bus_activity(bus_activity), .dev_ready(dev_ready),
	.block_operating_mode(block_operating_mode),
	.auto_setpoint(auto_setpoint), .block_setpoint(block_setpoint),
	.setpoint_wr(setpoint_wr), .raw_valve_command(raw_valve_command),
	.solenoid_drive_zero(solenoid_drive_zero),
	.solenoid_drive_one(solenoid_drive_one), .lamps(lamps),
	.position_readback(position_readback),
	.first_valve_transducer(first_valve_transducer),
	.io_raw_snapshot(io_raw_snapshot)
);

// file: bench/vsil_top_tb.sv
// self-checking bench for the valve status indicator logic
`timescale 1ns/1ps
module vsil_top_tb;
	import vsil_pkg::*;
	localparam int unsigned BL = 4;
	localparam int unsigned DB = 3;
	logic        core_clk;
	logic        rst_n;
	logic        clk_en;
	vsil_pins_t  pins_raw;
	logic        bus_activity;
	logic        dev_ready;
	vsil_cmd_t   auto_setpoint;
	vsil_cfg_t   cfg_in;
	logic        cfg_wr;
	vsil_mode_t  mode;
	vsil_cmd_t   sp;
	logic        sp_wr;
	vsil_cmd_t   cmd;
	logic        dz;
	logic        d1;
	vsil_lamps_t lamps;
	vsil_pos_t   rb;
	vsil_pos_t   fb;
	logic [3:0]  diag;
	vsil_cfg_t   fvt;
	vsil_snap_t  snap;
	int          err_count;
	int          total_checks;
	int          n;
	logic [15:0] lfsr;
	vsil_cmd_t   c;
	vsil_cfg_t   k;
	logic        d;
	logic        rev;
	logic [7:0]  pt [5] = '{8'h91, 8'h04, 8'h40, 8'h13, 8'h22};
	logic [3:0]  dt [3] = '{4'h6, 4'h1, 4'h8};

	vsil_top #(.SELFTEST_CYCLES(8), .BLINK_CYCLES(BL), .DEBOUNCE_CYCLES(DB)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.pins_raw(pins_raw), .bus_activity(bus_activity),
		.dev_ready(dev_ready), .block_operating_mode(mode),
		.auto_setpoint(auto_setpoint), .block_setpoint(sp),
		.setpoint_wr(sp_wr), .cfg_in(cfg_in), .cfg_wr(cfg_wr),
		.raw_valve_command(cmd), .solenoid_drive_zero(dz),
		.solenoid_drive_one(d1), .lamps(lamps), .position_readback(rb),
		.position_feedback_out(fb), .load_diag_status(diag),
		.first_valve_transducer(fvt), .io_raw_snapshot(snap));
	vsil_host_model host (.core_clk(core_clk), .block_operating_mode(mode),
		.block_setpoint(sp), .setpoint_wr(sp_wr));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// stop leaves a single coil where it was
	function automatic logic coil(input vsil_cmd_t v, input logic r,
		input logic p);
		return (v == VSIL_CMD_STOP) ? p : ((v == VSIL_CMD_OPEN) ^ r);
	endfunction

	task automatic tick(input int t);
		repeat (t) @(posedge core_clk);
	endtask
	task automatic settle();
		@(negedge core_clk);
	endtask
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// a full blink period holds exactly one half of lit samples
	task automatic highs(input int idx, output int h);
		h = 0;
		repeat (2 * BL) begin
			settle();
			h += (lamps[idx] === 1'b1) ? 1 : 0;
		end
	endtask
	task automatic cfg_put(input vsil_cfg_t v);
		@(posedge core_clk);
		cfg_in <= v;
		cfg_wr <= 1'b1;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		tick(3);
		settle();
		check(18'(fvt), 18'(v));
	endtask
	task automatic done(input string s);
		$display("test %0s ended, mismatches %0d", s, err_count);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		final_report();
	end

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		pins_raw = '0;
		bus_activity = 1'b0;
		dev_ready = 1'b0;
		auto_setpoint = VSIL_CMD_CLOSE;
		cfg_in = CFG_DEFAULT;
		cfg_wr = 1'b0;
		err_count = 0;
		total_checks = 0;
		lfsr = 16'hB058;
		tick(5);
		rst_n <= 1'b1;
		tick(3);
		settle();
		check(18'(lamps), 18'h7F);
		tick(8);
		settle();
		check(18'(lamps), 18'h0);
		tick(12);
		bus_activity <= 1'b1;
		tick(3);
		settle();
		check(18'(lamps.bus_lamp), 18'h1);
		tick(1);
		dev_ready <= 1'b1;
		tick(2);
		highs(6, n);
		check(18'(n), 18'(BL));
		tick(1);
		bus_activity <= 1'b0;
		tick(2);
		settle();
		check(18'(lamps.bus_lamp), 18'h0);
		done("lamps");
		for (int i = 0; i < 6; i++) begin
			tick(1);
			lfsr = lfsr_next(lfsr);
			pins_raw[3:0] <= lfsr[3:0];
			tick(DB + 6);
			settle();
			check(18'(lamps[5:2]), 18'({lfsr[0], lfsr[1], lfsr[2], lfsr[3]}));
			check(18'(snap), 18'({pins_raw, d1, dz}));
		end
		tick(1);
		pins_raw.spare_contact_two <= ~lfsr[3];
		tick(1);
		pins_raw.spare_contact_two <= lfsr[3];
		tick(DB + 6);
		settle();
		check(18'(lamps.spare_two_lamp), 18'(lfsr[3]));
		done("pins");
		tick(1);
		auto_setpoint <= VSIL_CMD_STOP;
		d = 1'b0;
		rev = 1'b0;
		for (int i = 0; i < 6; i++) begin
			if (i == 3) begin
				rev = 1'b1;
				k = CFG_DEFAULT;
				k.reverse = 1'b1;
				cfg_put(k);
			end
			c = vsil_cmd_t'(2'(i % 3));
			host.put(VSIL_MODE_MANUAL, c, 1'b1);
			tick(4);
			settle();
			d = coil(c, rev, d);
			check(18'(cmd), 18'(c));
			check(18'({dz, lamps.drive_zero_lamp}), 18'({d, d}));
		end
		tick(1);
		pins_raw.dip_sw[DIP_WRITE_PROT] <= 1'b1;
		tick(DB + 6);
		host.put(VSIL_MODE_MANUAL, VSIL_CMD_OPEN, 1'b1);
		pins_raw.dip_sw[DIP_WRITE_PROT] <= 1'b0;
		tick(DB + 6);
		host.put(VSIL_MODE_MANUAL, vsil_cmd_t'(2'h3), 1'b1);
		host.put(VSIL_MODE_OOS, VSIL_CMD_OPEN, 1'b1);
		tick(4);
		settle();
		check(18'(cmd), 18'(VSIL_CMD_STOP));
		for (int i = 0; i < 3; i++) begin
			tick(1);
			lfsr = lfsr_next(lfsr);
			c = vsil_cmd_t'(2'(lfsr % 3));
			auto_setpoint <= c;
			host.put(VSIL_MODE_AUTO, vsil_cmd_t'(2'((lfsr + 1) % 3)), 1'b1);
			tick(4);
			settle();
			check(18'(cmd), 18'(c));
		end
		done("commands");
		cfg_put(CFG_DEFAULT);
		for (int i = 0; i < 5; i++) begin
			host.put(VSIL_MODE_MANUAL, vsil_cmd_t'(pt[i][5:4]), 1'b1);
			pins_raw.top_sensor <= pt[i][7];
			pins_raw.bot_sensor <= pt[i][6];
			tick(DB + 8);
			settle();
			check(18'({rb, fb}), 18'({pt[i][2:0], pt[i][2:0]}));
		end
		done("position");
		k = CFG_DEFAULT;
		k.actuation_style = VSIL_STYLE_DUAL;
		cfg_put(k);
		for (int i = 0; i < 3; i++) begin
			host.put(VSIL_MODE_MANUAL, vsil_cmd_t'(dt[i][3:2]), 1'b1);
			tick(4);
			settle();
			check(18'({dz, d1}), 18'(dt[i][1:0]));
		end
		k = CFG_DEFAULT;
		k.out_sel = 1'b1;
		cfg_put(k);
		host.put(VSIL_MODE_MANUAL, VSIL_CMD_OPEN, 1'b1);
		pins_raw.load_open[1] <= 1'b1;
		tick(DB + 8);
		settle();
		check(18'(diag), 18'h2);
		highs(0, n);
		check(18'(n), 18'(BL));
		tick(1);
		pins_raw.load_open[1] <= 1'b0;
		tick(DB + 8);
		settle();
		check(18'({dz, d1, lamps.drive_one_lamp, diag}), 18'h30);
		done("drives");
		tick(1);
		pins_raw.dip_sw[DIP_FACTORY] <= 1'b1;
		tick(DB + 8);
		settle();
		check(18'(fvt), 18'(CFG_DEFAULT));
		highs(4, n);
		check(18'(n), 18'(BL));
		tick(1);
		clk_en <= 1'b0;
		highs(4, n);
		check(18'(n % (2 * BL)), 18'h0);
		done("config");
		final_report();
	end
endmodule

// file: hw/vsil_debounce.sv
// three-stage synchronizer and debounce filter for pin inputs
`timescale 1ns/1ps
module vsil_debounce #(
	parameter int unsigned W   = 4,
	parameter int unsigned CNT = 500_000
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	// pins
	input  wire logic [W-1:0] raw,
	// filtered
	output logic      [W-1:0] clean
);

	generate
		if (W < 1 || CNT < 1) begin : g_chk
			$error("vsil_debounce: W and CNT must be at least one");
		end
	endgenerate

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [31:0]  cnt_q [W];

	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (clk_en) begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a level is taken only after it stays put for the whole window
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			clean <= '0;
			for (int i = 0; i < W; i++) begin
				cnt_q[i] <= 32'h0;
			end
		end else if (clk_en) begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] != s3_q[i] || s3_q[i] == clean[i]) begin
					cnt_q[i] <= 32'h0;
				end else if (cnt_q[i] == 32'(CNT - 1)) begin
					cnt_q[i] <= 32'h0;
					clean[i] <= s3_q[i];
				end else begin
					cnt_q[i] <= cnt_q[i] + 32'h1;
				end
			end
		end
	end

endmodule

// file: hw/vsil_top.sv
// lamp driver, valve command and position feedback for one controller
`timescale 1ns/1ps
module vsil_top
	import vsil_pkg::*;
#(
	parameter int unsigned SELFTEST_CYCLES = vsil_pkg::SELFTEST_CYC,
	parameter int unsigned BLINK_CYCLES    = vsil_pkg::BLINK_HALF_CYC,
	parameter int unsigned DEBOUNCE_CYCLES = vsil_pkg::DEBOUNCE_CYC
) (
	// clock, reset, enable
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   clk_en,
	// field pins
	input  wire vsil_pkg::vsil_pins_t   pins_raw,
	// bus status from the communication core
	input  wire logic                   bus_activity,
	input  wire logic                   dev_ready,
	// host block parameters
	input  wire vsil_pkg::vsil_mode_t   block_operating_mode,
	input  wire vsil_pkg::vsil_cmd_t    auto_setpoint,
	input  wire vsil_pkg::vsil_cmd_t    block_setpoint,
	input  wire logic                   setpoint_wr,
	input  wire vsil_pkg::vsil_cfg_t    cfg_in,
	input  wire logic                   cfg_wr,
	// solenoid drives
	output vsil_pkg::vsil_cmd_t         raw_valve_command,
	output logic                        solenoid_drive_zero,
	output logic                        solenoid_drive_one,
	// lamps
	output vsil_pkg::vsil_lamps_t       lamps,
	// feedback and diagnostics
	output vsil_pkg::vsil_pos_t         position_readback,
	output vsil_pkg::vsil_pos_t         position_feedback_out,
	output logic [3:0]                  load_diag_status,
	output vsil_pkg::vsil_cfg_t         first_valve_transducer,
	output vsil_pkg::vsil_snap_t        io_raw_snapshot
);

	import vsil_pkg::*;

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	generate
		if (SELFTEST_CYCLES < 1 || BLINK_CYCLES < 1 ||
		    DEBOUNCE_CYCLES < 1) begin : g_chk
			$error("vsil_top: cycle counts must be at least one");
		end
	endgenerate

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic pick(input vsil_sel_t s,
	                              input vsil_pins_t p);
		case (s)
			VSIL_SEL_TOP:  pick = p.top_sensor;
			VSIL_SEL_BOT:  pick = p.bot_sensor;
			VSIL_SEL_SPR1: pick = p.spare_contact_one;
			default:       pick = p.spare_contact_two;
		endcase
	endfunction

	// drive level for coil a at out_sel, coil b at the other output
	function automatic logic [1:0] place(input logic a, input logic b,
	                                     input logic sel);
		place = sel ? {a, b} : {b, a};
	endfunction

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	vsil_pins_t pins_q;

	vsil_debounce #(
		.W   ($bits(vsil_pins_t)),
		.CNT (DEBOUNCE_CYCLES)
	) u_dbc (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.raw      (pins_raw),
		.clean    (pins_q)
	);

	wire logic factory_act = pins_q.dip_sw[DIP_FACTORY];
	wire logic write_prot  = pins_q.dip_sw[DIP_WRITE_PROT];

	// ----------------------------------------------------------------
	// shared blink divider
	// ----------------------------------------------------------------
	logic [31:0] blink_cnt_q;
	logic        blink_q;

	// one divider so every flashing lamp stays in phase
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			blink_cnt_q <= 32'h0;
			blink_q     <= 1'b0;
		end else if (clk_en) begin
			if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
				blink_cnt_q <= 32'h0;
				blink_q     <= ~blink_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 32'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// power-up lamp self-test
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		VSIL_ST_ON  = 3'b001,
		VSIL_ST_OFF = 3'b010,
		VSIL_ST_RUN = 3'b100
	} vsil_st_t;

	vsil_st_t    st_q;
	vsil_st_t    st_d;
	logic [31:0] st_cnt_q;

	wire logic st_done = (st_cnt_q == 32'(SELFTEST_CYCLES - 1));

	always_comb begin
		st_d = st_q;
		case (st_q)
			VSIL_ST_ON:  if (st_done) st_d = VSIL_ST_OFF;
			VSIL_ST_OFF: if (st_done) st_d = VSIL_ST_RUN;
			VSIL_ST_RUN: st_d = VSIL_ST_RUN;
			default:     st_d = VSIL_ST_ON;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_q     <= VSIL_ST_ON;
			st_cnt_q <= 32'h0;
		end else if (clk_en) begin
			st_q <= st_d;
			if (st_done || st_q == VSIL_ST_RUN) begin
				st_cnt_q <= 32'h0;
			end else begin
				st_cnt_q <= st_cnt_q + 32'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// transducer configuration
	// ----------------------------------------------------------------
	vsil_cfg_t cfg_q;

	// restore holds the defaults for as long as the switch is on
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_q <= CFG_DEFAULT;
		end else if (clk_en) begin
			if (factory_act) begin
				cfg_q <= CFG_DEFAULT;
			end else if (cfg_wr && !write_prot) begin
				cfg_q <= cfg_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// command path
	// ----------------------------------------------------------------
	vsil_cmd_t cmd_q;

	wire logic is_manual = (block_operating_mode == VSIL_MODE_MANUAL);
	wire logic is_auto   = (block_operating_mode == VSIL_MODE_AUTO);
	wire logic sp_legal  = (block_setpoint != 2'h3);
	wire logic man_take  = is_manual && setpoint_wr && sp_legal &&
	                       !write_prot;
	wire logic auto_take = is_auto && (auto_setpoint != 2'h3);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmd_q <= VSIL_CMD_CLOSE;
		end else if (clk_en) begin
			if (man_take) begin
				cmd_q <= block_setpoint;
			end else if (auto_take) begin
				cmd_q <= auto_setpoint;
			end
		end
	end

	// ----------------------------------------------------------------
	// output drive
	// ----------------------------------------------------------------
	logic [1:0] drive_q;
	logic [1:0] drive_d;

	wire logic coil_a_now = cfg_q.out_sel ? drive_q[1] : drive_q[0];
	wire logic want_open  = (cmd_q == VSIL_CMD_OPEN);
	wire logic want_close = (cmd_q == VSIL_CMD_CLOSE);
	// reverse action swaps which command powers the coil
	wire logic single_on  = want_open ^ cfg_q.reverse;
	wire logic dual_a     = cfg_q.reverse ? want_close : want_open;
	wire logic dual_b     = cfg_q.reverse ? want_open : want_close;

	always_comb begin
		drive_d = 2'h0;
		case (cfg_q.actuation_style)
			VSIL_STYLE_SINGLE: begin
				// a single coil cannot stop mid-stroke; hold it
				if (cmd_q == VSIL_CMD_STOP) begin
					drive_d = place(coil_a_now, 1'b0, cfg_q.out_sel);
				end else begin
					drive_d = place(single_on, 1'b0, cfg_q.out_sel);
				end
			end
			VSIL_STYLE_DUAL: begin
				// stop leaves both dual_a and dual_b low
				drive_d = place(dual_a, dual_b, cfg_q.out_sel);
			end
			default: drive_d = 2'h0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			drive_q <= 2'h0;
		end else if (clk_en) begin
			drive_q <= drive_d;
		end
	end

	// ----------------------------------------------------------------
	// position feedback
	// ----------------------------------------------------------------
	vsil_pos_t pos_q;
	vsil_pos_t pos_d;

	wire logic open_act  = pick(cfg_q.open_sel, pins_q);
	wire logic close_act = pick(cfg_q.close_sel, pins_q);

	always_comb begin
		pos_d = pos_q;
		if (open_act) begin
			pos_d = VSIL_POS_OPENED;
		end else if (close_act) begin
			pos_d = VSIL_POS_CLOSED;
		end else if (cmd_q == VSIL_CMD_STOP) begin
			pos_d = VSIL_POS_STOPPED;
		end else if (pos_q == VSIL_POS_CLOSED) begin
			pos_d = VSIL_POS_OPENING;
		end else if (pos_q == VSIL_POS_OPENED) begin
			pos_d = VSIL_POS_CLOSING;
		end else if (pos_q == VSIL_POS_STOPPED) begin
			pos_d = want_open ? VSIL_POS_OPENING : VSIL_POS_CLOSING;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pos_q <= VSIL_POS_STOPPED;
		end else if (clk_en) begin
			pos_q <= pos_d;
		end
	end

	// ----------------------------------------------------------------
	// load diagnostics
	// ----------------------------------------------------------------
	// a fault only means something while the output is energized
	wire logic [1:0] open_flt  = drive_q & pins_q.load_open;
	wire logic [1:0] short_flt = drive_q & pins_q.load_short;
	wire logic [1:0] load_flt  = open_flt | short_flt;

	// ----------------------------------------------------------------
	// lamp selection
	// ----------------------------------------------------------------
	vsil_lamps_t lamp_norm;
	vsil_lamps_t lamp_d;

	wire logic bus_lamp_w = bus_activity && (!dev_ready || blink_q);

	assign lamp_norm.bus_lamp         = bus_lamp_w;
	assign lamp_norm.upper_limit_lamp = factory_act ? blink_q :
	                                    pins_q.top_sensor;
	assign lamp_norm.lower_limit_lamp = factory_act ? blink_q :
	                                    pins_q.bot_sensor;
	assign lamp_norm.spare_one_lamp   = factory_act ? blink_q :
	                                    pins_q.spare_contact_one;
	assign lamp_norm.spare_two_lamp   = factory_act ? blink_q :
	                                    pins_q.spare_contact_two;
	assign lamp_norm.drive_zero_lamp  = drive_q[0] &&
	                                    (!load_flt[0] || blink_q);
	assign lamp_norm.drive_one_lamp   = drive_q[1] &&
	                                    (!load_flt[1] || blink_q);

	always_comb begin
		case (st_q)
			VSIL_ST_ON:  lamp_d = '1;
			VSIL_ST_OFF: lamp_d = '0;
			VSIL_ST_RUN: lamp_d = lamp_norm;
			default:     lamp_d = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lamps                  <= '0;
			solenoid_drive_zero    <= 1'b0;
			solenoid_drive_one     <= 1'b0;
			raw_valve_command      <= VSIL_CMD_CLOSE;
			position_readback      <= VSIL_POS_STOPPED;
			position_feedback_out  <= VSIL_POS_STOPPED;
			load_diag_status       <= 4'h0;
			first_valve_transducer <= CFG_DEFAULT;
			io_raw_snapshot        <= '0;
		end else if (clk_en) begin
			lamps                  <= lamp_d;
			solenoid_drive_zero    <= drive_q[0];
			solenoid_drive_one     <= drive_q[1];
			raw_valve_command      <= cmd_q;
			position_readback      <= pos_q;
			position_feedback_out  <= pos_q;
			load_diag_status       <= {short_flt, open_flt};
			first_valve_transducer <= cfg_q;
			io_raw_snapshot        <= '{pins: pins_q, drives: drive_q};
		end
	end

endmodule

// file: pkg/vsil_pkg.sv
// constants, types and defaults of the valve status indicator logic
//
// Operation
// - at power-up every lamp flashes once, then shows its normal function
// - bus lamp: steady traffic-not-ready, flashing traffic-ready, dark idle
// - upper-limit lamp follows the top magnetic limit sensor
// - lower-limit lamp follows the bottom magnetic limit sensor
// - during factory restore the limit and spare-contact lamps flash
// - first spare-contact lamp lit while its dry contact is closed
// - second spare-contact lamp lit while its dry contact is closed
// - drive-zero lamp steady when energized with normal load, dark when de-energized
// - drive-one lamp steady when energized with normal load, dark when de-energized
// - energized output with open or shorted load flashes and is recorded
// - raw valve command written in manual and in auto: 0 close, 1 open, 2 stop
// - feedback codes: 0 closed, 1 opened, 2 stopped, 3 opening, 4 closing
// - raw position reads opened whenever the opened switch is active
// - manual mode commands outputs directly, bypassing the automatic path
// - raw snapshot exposes every field pin, drive output and configuration switch
// - factory restore maps transducer to top, bottom sensors and output zero
// - factory restore selects increase-to-open and single-coil actuation
// - direct action energizes on open; reverse action de-energizes on open
// - opening after closed switch releases, closing after opened releases
// - dual-coil stop de-energizes both outputs to halt the valve
package vsil_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 50_000_000;
	localparam int unsigned SELFTEST_MS    = 500;
	localparam int unsigned BLINK_HALF_MS  = 250;
	localparam int unsigned DEBOUNCE_MS    = 10;
	localparam int unsigned SELFTEST_CYC   = CLK_HZ / 1000 * SELFTEST_MS;
	localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int unsigned DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;

	// ----------------------------------------------------------------
	// configuration switch positions
	// ----------------------------------------------------------------
	localparam int unsigned DIP_WRITE_PROT = 0;
	localparam int unsigned DIP_FACTORY    = 2;
	localparam int unsigned DIP_COUNT      = 6;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		VSIL_CMD_CLOSE = 2'h0,
		VSIL_CMD_OPEN  = 2'h1,
		VSIL_CMD_STOP  = 2'h2
	} vsil_cmd_t;

	typedef enum logic [2:0] {
		VSIL_POS_CLOSED  = 3'h0,
		VSIL_POS_OPENED  = 3'h1,
		VSIL_POS_STOPPED = 3'h2,
		VSIL_POS_OPENING = 3'h3,
		VSIL_POS_CLOSING = 3'h4
	} vsil_pos_t;

	typedef enum logic [1:0] {
		VSIL_STYLE_SINGLE  = 2'h0,
		VSIL_STYLE_DUAL    = 2'h1,
		VSIL_STYLE_MONITOR = 2'h2
	} vsil_style_t;

	typedef enum logic [1:0] {
		VSIL_MODE_AUTO   = 2'h0,
		VSIL_MODE_MANUAL = 2'h1,
		VSIL_MODE_OOS    = 2'h2
	} vsil_mode_t;

	typedef enum logic [1:0] {
		VSIL_SEL_TOP  = 2'h0,
		VSIL_SEL_BOT  = 2'h1,
		VSIL_SEL_SPR1 = 2'h2,
		VSIL_SEL_SPR2 = 2'h3
	} vsil_sel_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		vsil_sel_t   open_sel;
		vsil_sel_t   close_sel;
		logic        out_sel;
		logic        reverse;
		vsil_style_t actuation_style;
	} vsil_cfg_t;

	localparam vsil_cfg_t CFG_DEFAULT = '{
		open_sel:        VSIL_SEL_TOP,
		close_sel:       VSIL_SEL_BOT,
		out_sel:         1'b0,
		reverse:         1'b0,
		actuation_style: VSIL_STYLE_SINGLE
	};

	typedef struct packed {
		logic [DIP_COUNT-1:0] dip_sw;
		logic [1:0]           load_short;
		logic [1:0]           load_open;
		logic                 spare_contact_two;
		logic                 spare_contact_one;
		logic                 bot_sensor;
		logic                 top_sensor;
	} vsil_pins_t;

	typedef struct packed {
		logic bus_lamp;
		logic upper_limit_lamp;
		logic lower_limit_lamp;
		logic spare_one_lamp;
		logic spare_two_lamp;
		logic drive_zero_lamp;
		logic drive_one_lamp;
	} vsil_lamps_t;

	typedef struct packed {
		vsil_pins_t pins;
		logic [1:0] drives;
	} vsil_snap_t;

endpackage
